// file: verilog/cpuitd_consts.svh
// Constants for the instruction length and timing decoder.
// Assumes standard one-byte opcodes arriving from the fetch stage.
`ifndef CPUITD_CONSTS_SVH
`define CPUITD_CONSTS_SVH

`define CPUITD_LEN_W        2
`define CPUITD_CYC_W        3
`define CPUITD_LEN_1        2'H1
`define CPUITD_LEN_2        2'H2
`define CPUITD_LEN_3        2'H3
`define CPUITD_CYC_1        3'H1
`define CPUITD_CYC_2        3'H2
`define CPUITD_CYC_3        3'H3
`define CPUITD_CYC_CODE_MIN 3'H4
`define CPUITD_CNT_ZERO     3'H0
`define CPUITD_CNT_ONE      3'H1

`define CPUITD_HI_ADD       4'H2
`define CPUITD_HI_ADD_WITH_CARRY_OP      4'H3
`define CPUITD_HI_ORL       4'H4
`define CPUITD_HI_ANL       4'H5
`define CPUITD_HI_XRL       4'H6
`define CPUITD_HI_SUBTRACT_WITH_BORROW_OP      4'H9
`define CPUITD_HI_MOVRD     4'HA
`define CPUITD_LO_DIRA      4'H2
`define CPUITD_LO_DIRIMM    4'H3
`define CPUITD_LO_IMM       4'H4
`define CPUITD_LO_DIR       4'H5
`define CPUITD_LO_IND       3'H3
`define CPUITD_LO_ROT       4'H3
`define CPUITD_HI_RR        4'H0
`define CPUITD_HI_RRC       4'H1
`define CPUITD_HI_RL        4'H2
`define CPUITD_HI_RLC       4'H3

`define CPUITD_OP_MOVDD     8'H85
`define CPUITD_OP_MOVDPTR   8'H90
`define CPUITD_OP_CODEPC    8'H83
`define CPUITD_OP_CODEDPTR  8'H93
`define CPUITD_OP_XRDDPTR   8'HE0
`define CPUITD_OP_XWRDPTR   8'HF0
`define CPUITD_OP_XRDIND    7'H71
`define CPUITD_OP_XWRIND    7'H79
`define CPUITD_OP_PUSH      8'HC0
`define CPUITD_OP_POP       8'HD0
`define CPUITD_OP_XCHDIR    8'HC5
`define CPUITD_OP_XCHDIND   7'H6B
`define CPUITD_OP_STAIND    7'H7B
`define CPUITD_OP_IMMIND    7'H3B

`define CPUITD_SFR_BIT      7
`define CPUITD_BYTE_ZERO    8'H00

`endif

// file: verilog/cpuitd_pkg.sv
// Types shared by the instruction length and timing decoder.
// Assumes cpuitd_consts.svh is on the include path.
`include "cpuitd_consts.svh"

package cpuitd_pkg;

    typedef enum logic [3:0] {
        MD_NONE   = 4'H0,
        MD_REG    = 4'H1,
        MD_IND    = 4'H2,
        MD_DIR    = 4'H3,
        MD_IMM    = 4'H4,
        MD_DIRIMM = 4'H5,
        MD_DIRDIR = 4'H6,
        MD_WIDE   = 4'H7,
        MD_CODE   = 4'H8,
        MD_XIND   = 4'H9,
        MD_XDPTR  = 4'HA,
        MD_STACK  = 4'HB
    } cpuitd_mode_t;

    typedef enum logic [3:0] {
        ALU_NONE = 4'H0,
        ALU_ADD  = 4'H1,
        ALU_ADD_WITH_CARRY_OP = 4'H2,
        ALU_SUBTRACT_WITH_BORROW_OP = 4'H3,
        ALU_AND  = 4'H4,
        ALU_OR   = 4'H5,
        ALU_XOR  = 4'H6,
        ALU_RL   = 4'H7,
        ALU_RLC  = 4'H8,
        ALU_RR   = 4'H9,
        ALU_RRC  = 4'HA
    } cpuitd_alu_t;

    typedef struct packed {
        logic                      known;
        logic [`CPUITD_LEN_W-1:0]  len;
        logic [`CPUITD_CYC_W-1:0]  cycles;
        cpuitd_mode_t              mode;
        cpuitd_alu_t               alu;
        logic                      wrDirect;
        logic [4:0]                regAddr;
        logic                      dirIsSfr;
    } cpuitd_info_t;

    typedef struct packed {
        logic                      busy;
        logic [`CPUITD_CYC_W-1:0]  remain;
        cpuitd_info_t              info;
        logic [7:0]                result;
        logic                      carry;
    } cpuitd_state_t;

endpackage

// file: verilog/cpuitd_decode.sv
// Instruction length and execution timing decoder with operand ALU.
// Assumes opcode, operand bytes, bank and prefetch extra wait come from
// logic on clk_sys; no pin inputs reach it directly.
`timescale 1ns/1ps
`include "cpuitd_consts.svh"

module cpuitd_decode (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      decReq,
    input  wire logic [7:0]                decOpcode,
    input  wire logic [7:0]                directAddr,
    input  wire logic [1:0]                bankSel,
    input  wire logic [1:0]                codeExtraWait,
    input  wire logic [7:0]                accIn,
    input  wire logic [7:0]                operandIn,
    input  wire logic                      carryIn,
    output logic                           decReady,
    output logic                           execBusy,
    output logic                           execDone,
    output cpuitd_pkg::cpuitd_info_t       execInfo,
    output logic [7:0]                     aluResult,
    output logic                           aluCarry
);

    cpuitd_pkg::cpuitd_state_t state_ff;
    cpuitd_pkg::cpuitd_state_t nxt_state;
    cpuitd_pkg::cpuitd_info_t  dec;
    logic [3:0]                opHi;
    logic [3:0]                opLo;
    logic                      isArith;
    logic                      isLogic;
    logic                      isAluForm;
    logic [2:0]                regIdx;
    logic                      ptrIdx;
    logic                      lastCycle;
    logic                      take;
    logic [8:0]                wideSum;
    logic [7:0]                aluRes;
    logic                      aluCy;

    assign opHi = decOpcode[7:4];
    assign opLo = decOpcode[3:0];
    assign isArith = (opHi == `CPUITD_HI_ADD) || (opHi == `CPUITD_HI_ADD_WITH_CARRY_OP) ||
                     (opHi == `CPUITD_HI_SUBTRACT_WITH_BORROW_OP);
    assign isLogic = (opHi == `CPUITD_HI_ORL) || (opHi == `CPUITD_HI_ANL) ||
                     (opHi == `CPUITD_HI_XRL);

    // The arithmetic rows also hold branches, the pointer load and the code read;
    // only these low nibbles are ALU operand forms, the rest must fall through
    assign isAluForm = opLo[3] || (opLo[3:1] == `CPUITD_LO_IND) ||
                       (opLo == `CPUITD_LO_DIR) || (opLo == `CPUITD_LO_IMM) ||
                       (isLogic && (opLo == `CPUITD_LO_DIRA || opLo == `CPUITD_LO_DIRIMM));

    // Register forms index the bank with three bits, pointer forms with one
    assign regIdx  = decOpcode[2:0];
    assign ptrIdx  = decOpcode[0];

    // Opcode to length, timing, operand form and ALU function
    always_comb begin
        dec          = '0;
        dec.len      = `CPUITD_LEN_1;
        dec.cycles   = `CPUITD_CYC_1;
        dec.mode     = cpuitd_pkg::MD_NONE;
        dec.alu      = cpuitd_pkg::ALU_NONE;
        dec.dirIsSfr = directAddr[`CPUITD_SFR_BIT];
        // Rotates sit in column 3 of the first four rows
        if (opLo == `CPUITD_LO_ROT && opHi <= `CPUITD_HI_RLC) begin
            dec.known = 1'b1;
            unique case (opHi)
                `CPUITD_HI_RR:  dec.alu = cpuitd_pkg::ALU_RR;
                `CPUITD_HI_RRC: dec.alu = cpuitd_pkg::ALU_RRC;
                `CPUITD_HI_RL:  dec.alu = cpuitd_pkg::ALU_RL;
                default:        dec.alu = cpuitd_pkg::ALU_RLC;
            endcase
        end else if ((isArith || isLogic) && isAluForm) begin
            unique case (opHi)
                `CPUITD_HI_ADD:  dec.alu = cpuitd_pkg::ALU_ADD;
                `CPUITD_HI_ADD_WITH_CARRY_OP: dec.alu = cpuitd_pkg::ALU_ADD_WITH_CARRY_OP;
                `CPUITD_HI_SUBTRACT_WITH_BORROW_OP: dec.alu = cpuitd_pkg::ALU_SUBTRACT_WITH_BORROW_OP;
                `CPUITD_HI_ORL:  dec.alu = cpuitd_pkg::ALU_OR;
                `CPUITD_HI_ANL:  dec.alu = cpuitd_pkg::ALU_AND;
                default:         dec.alu = cpuitd_pkg::ALU_XOR;
            endcase
            if (opLo[3]) begin
                dec.known = 1'b1;
                dec.mode  = cpuitd_pkg::MD_REG;
            end else if (opLo[3:1] == `CPUITD_LO_IND) begin
                dec.known  = 1'b1;
                dec.mode   = cpuitd_pkg::MD_IND;
                dec.cycles = `CPUITD_CYC_2;
            end else if (opLo == `CPUITD_LO_DIR) begin
                dec.known  = 1'b1;
                dec.mode   = cpuitd_pkg::MD_DIR;
                dec.len    = `CPUITD_LEN_2;
                dec.cycles = `CPUITD_CYC_2;
            end else if (opLo == `CPUITD_LO_IMM) begin
                dec.known  = 1'b1;
                dec.mode   = cpuitd_pkg::MD_IMM;
                dec.len    = `CPUITD_LEN_2;
                dec.cycles = `CPUITD_CYC_2;
            end else if (isLogic && opLo == `CPUITD_LO_DIRA) begin
                dec.known    = 1'b1;
                dec.mode     = cpuitd_pkg::MD_DIR;
                dec.wrDirect = 1'b1;
                dec.len      = `CPUITD_LEN_2;
                dec.cycles   = `CPUITD_CYC_2;
            end else if (isLogic && opLo == `CPUITD_LO_DIRIMM) begin
                dec.known    = 1'b1;
                dec.mode     = cpuitd_pkg::MD_DIRIMM;
                dec.wrDirect = 1'b1;
                dec.len      = `CPUITD_LEN_3;
                dec.cycles   = `CPUITD_CYC_3;
            end else begin
                dec.alu = cpuitd_pkg::ALU_NONE;
            end
        end else if (opHi == `CPUITD_HI_MOVRD && opLo[3]) begin
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_DIR;
            dec.len    = `CPUITD_LEN_2;
            dec.cycles = `CPUITD_CYC_2;
        end else if (decOpcode == `CPUITD_OP_MOVDD) begin
            // Both addresses travel with the opcode, hence three bytes
            dec.known    = 1'b1;
            dec.mode     = cpuitd_pkg::MD_DIRDIR;
            dec.wrDirect = 1'b1;
            dec.len      = `CPUITD_LEN_3;
            dec.cycles   = `CPUITD_CYC_3;
        end else if (decOpcode[7:1] == `CPUITD_OP_STAIND) begin
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_IND;
            dec.cycles = `CPUITD_CYC_2;
        end else if (decOpcode[7:1] == `CPUITD_OP_IMMIND) begin
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_IND;
            dec.len    = `CPUITD_LEN_2;
            dec.cycles = `CPUITD_CYC_2;
        end else if (decOpcode == `CPUITD_OP_MOVDPTR) begin
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_WIDE;
            dec.len    = `CPUITD_LEN_3;
            dec.cycles = `CPUITD_CYC_3;
        end else if (decOpcode == `CPUITD_OP_CODEDPTR) begin
            // Extra wait reflects prefetch buffer state; the sum tops out at seven
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_CODE;
            dec.cycles = `CPUITD_CYC_CODE_MIN + {1'b0, codeExtraWait};
        end else if (decOpcode == `CPUITD_OP_CODEPC) begin
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_CODE;
            dec.cycles = `CPUITD_CYC_3;
        end else if (decOpcode[7:1] == `CPUITD_OP_XRDIND ||
                     decOpcode[7:1] == `CPUITD_OP_XWRIND) begin
            // External moves share one timing in both directions
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_XIND;
            dec.cycles = `CPUITD_CYC_3;
        end else if (decOpcode == `CPUITD_OP_XRDDPTR ||
                     decOpcode == `CPUITD_OP_XWRDPTR) begin
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_XDPTR;
            dec.cycles = `CPUITD_CYC_3;
        end else if (decOpcode == `CPUITD_OP_PUSH ||
                     decOpcode == `CPUITD_OP_POP) begin
            // Only the pop lands in its direct byte; the push writes the stack
            dec.known    = 1'b1;
            dec.mode     = cpuitd_pkg::MD_STACK;
            dec.wrDirect = (decOpcode == `CPUITD_OP_POP);
            dec.len      = `CPUITD_LEN_2;
            dec.cycles   = `CPUITD_CYC_2;
        end else if (decOpcode == `CPUITD_OP_XCHDIR) begin
            dec.known    = 1'b1;
            dec.mode     = cpuitd_pkg::MD_DIR;
            dec.wrDirect = 1'b1;
            dec.len      = `CPUITD_LEN_2;
            dec.cycles   = `CPUITD_CYC_2;
        end else if (decOpcode[7:1] == `CPUITD_OP_XCHDIND) begin
            dec.known  = 1'b1;
            dec.mode   = cpuitd_pkg::MD_IND;
            dec.cycles = `CPUITD_CYC_2;
        end else begin
            // Unlisted opcodes still pass as one byte and one cycle, so the core never stalls
            dec.known = 1'b0;
        end

        // Register file address: bank in the top two bits
        // Only the first two registers can point, so the middle bits are forced low
        if (dec.mode == cpuitd_pkg::MD_IND || dec.mode == cpuitd_pkg::MD_XIND) begin
            dec.regAddr = {bankSel, 2'H0, ptrIdx};
        end else begin
            dec.regAddr = {bankSel, regIdx};
        end
    end

    // Accumulator ALU; carry is both the add-in and the incoming borrow
    always_comb begin
        wideSum = 9'H000;
        aluRes  = accIn;
        aluCy   = carryIn;
        unique case (dec.alu)
            cpuitd_pkg::ALU_ADD: begin
                wideSum = {1'b0, accIn} + {1'b0, operandIn};
                aluRes  = wideSum[7:0];
                aluCy   = wideSum[8];
            end
            cpuitd_pkg::ALU_ADD_WITH_CARRY_OP: begin
                wideSum = {1'b0, accIn} + {1'b0, operandIn} + {8'H00, carryIn};
                aluRes  = wideSum[7:0];
                aluCy   = wideSum[8];
            end
            cpuitd_pkg::ALU_SUBTRACT_WITH_BORROW_OP: begin
                wideSum = {1'b0, accIn} - {1'b0, operandIn} - {8'H00, carryIn};
                aluRes  = wideSum[7:0];
                aluCy   = wideSum[8];
            end
            // Logic results leave the carry untouched
            cpuitd_pkg::ALU_AND: aluRes = accIn & operandIn;
            cpuitd_pkg::ALU_OR:  aluRes = accIn | operandIn;
            cpuitd_pkg::ALU_XOR: aluRes = accIn ^ operandIn;
            // Plain rotates leave the carry alone too
            cpuitd_pkg::ALU_RL:  aluRes = {accIn[6:0], accIn[7]};
            cpuitd_pkg::ALU_RLC: begin
                aluRes = {accIn[6:0], carryIn};
                aluCy  = accIn[7];
            end
            cpuitd_pkg::ALU_RR:  aluRes = {accIn[0], accIn[7:1]};
            cpuitd_pkg::ALU_RRC: begin
                aluRes = {carryIn, accIn[7:1]};
                aluCy  = accIn[0];
            end
            default: aluRes = accIn;
        endcase
    end

    // Ready in the last busy cycle so instructions issue back to back
    // Counting down to zero needs one comparator whatever the length
    assign lastCycle = state_ff.busy && (state_ff.remain == `CPUITD_CNT_ZERO);
    assign take      = decReq && (!state_ff.busy || lastCycle);

    always_comb begin
        nxt_state = state_ff;
        // A take in the last cycle wins over the drop to idle
        if (take) begin
            nxt_state.busy   = 1'b1;
            nxt_state.remain = dec.cycles - `CPUITD_CNT_ONE;
            nxt_state.info   = dec;
            nxt_state.result = aluRes;
            nxt_state.carry  = aluCy;
        end else if (lastCycle) begin
            nxt_state.busy = 1'b0;
        end else if (state_ff.busy) begin
            nxt_state.remain = state_ff.remain - `CPUITD_CNT_ONE;
        end
    end

    // Reset clears the held info too, so a stale length never reads as valid
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign decReady  = !state_ff.busy || lastCycle;
    assign execBusy  = state_ff.busy;
    // Done comes from the count, not a flop of its own
    assign execDone  = lastCycle;
    // Info and result hold until the next take
    assign execInfo  = state_ff.info;
    assign aluResult = state_ff.result;
    assign aluCarry  = state_ff.carry;

endmodule

// file: tb/cpuitd_monitor.sv
// Concurrent checks on the ports of the instruction length and timing decoder.
// Assumes it is bound to cpuitd_decode and sees nothing but its ports.
`timescale 1ns/1ps

module cpuitd_monitor (
    input wire logic                     clk_sys,
    input wire logic                     rst,
    input wire logic                     decReq,
    input wire logic [7:0]               decOpcode,
    input wire logic [7:0]               directAddr,
    input wire logic [1:0]               bankSel,
    input wire logic [1:0]               codeExtraWait,
    input wire logic [7:0]               accIn,
    input wire logic [7:0]               operandIn,
    input wire logic                     carryIn,
    input wire logic                     decReady,
    input wire logic                     execBusy,
    input wire logic                     execDone,
    input wire cpuitd_pkg::cpuitd_info_t execInfo,
    input wire logic [7:0]               aluResult,
    input wire logic                     aluCarry
);
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic       take;
    logic [4:0] regSel;
    logic [4:0] ptrSel;
    logic [8:0] sumC;
    logic [8:0] diffB;
    assign take   = decReq && decReady;
    assign regSel = {bankSel, decOpcode[2:0]};
    assign ptrSel = {bankSel, 2'H0, decOpcode[0]};
    assign sumC   = {1'H0, accIn} + {1'H0, operandIn} + {8'H0, carryIn};
    assign diffB  = {1'H0, accIn} - {1'H0, operandIn} - {8'H0, carryIn};

    a_reg_arith_one: assert property (
        take && decOpcode[3] && decOpcode[7:4] inside {4'H2, 4'H3, 4'H9} |=> execDone && execInfo.len == 2'H1)
        else $error("register arithmetic not one byte and one cycle");
    a_dir_arith_two: assert property (
        take && decOpcode inside {8'H25, 8'H35, 8'H95} |=> !execDone && execInfo.len == 2'H2 ##1 execDone)
        else $error("direct arithmetic not two bytes and two cycles");
    a_ind_arith_two: assert property (
        take && decOpcode[7:4] inside {4'H2, 4'H3, 4'H9} && decOpcode[3:1] == 3'H3
        |=> !execDone && execInfo.len == 2'H1 ##1 execDone)
        else $error("indirect arithmetic not one byte and two cycles");
    a_logic_imm_three: assert property (
        take && decOpcode inside {8'H43, 8'H53, 8'H63} |=> (!execDone) [*2] ##1 execDone && execInfo.len == 2'H3)
        else $error("immediate to direct logic not three cycles");
    a_rotate_one: assert property (
        take && decOpcode inside {8'H03, 8'H13, 8'H23, 8'H33} |=> execDone && execInfo.len == 2'H1)
        else $error("rotate not one byte and one cycle");
    a_ext_move_three: assert property (
        take && decOpcode inside {8'H83, 8'HE0, 8'HE2, 8'HE3, 8'HF0, 8'HF2, 8'HF3}
        |=> (!execDone) [*2] ##1 execDone && execInfo.len == 2'H1)
        else $error("external or code move not three cycles");
    a_code_read_wait: assert property (
        take && decOpcode == 8'H93
        |=> (!execDone) [*3] ##1 execInfo.cycles == 3'H4 + {1'H0, $past(codeExtraWait, 4)})
        else $error("code read via pointer has wrong latency");
    a_bank_reg_sel: assert property (
        take && decOpcode[3] && decOpcode[7:4] inside {4'H2, 4'H3, 4'H4, 4'H5, 4'H6, 4'H9, 4'HA}
        |=> execInfo.regAddr == $past(regSel))
        else $error("working register address wrong");
    a_ind_ptr_sel: assert property (
        take && decOpcode[3:1] == 3'H3 && decOpcode[7:4] inside {4'H2, 4'H3, 4'H5, 4'H7, 4'HD, 4'HF}
        |=> execInfo.regAddr == $past(ptrSel))
        else $error("pointer register address wrong");
    a_sfr_select: assert property (
        take && decOpcode == 8'H25 |=> execInfo.dirIsSfr == $past(directAddr[7]))
        else $error("special register flag wrong");
    a_carry_in_sum: assert property (
        take && decOpcode == 8'H34 |=> {aluCarry, aluResult} == $past(sumC))
        else $error("add with carry result wrong");
    a_borrow_sub: assert property (
        take && decOpcode == 8'H94 |=> {aluCarry, aluResult} == $past(diffB))
        else $error("subtract with borrow result wrong");

    c_back_to_back: cover property (execDone && take);
    c_code_slowest: cover property (take && decOpcode == 8'H93 && codeExtraWait == 2'H3);
    c_borrow_out: cover property (take && decOpcode[7:4] == 4'H9 && diffB[8]);
endmodule

bind cpuitd_decode cpuitd_monitor u_mon (
    .clk_sys(clk_sys), .rst(rst), .decReq(decReq), .decOpcode(decOpcode), .directAddr(directAddr),
    .bankSel(bankSel), .codeExtraWait(codeExtraWait), .accIn(accIn), .operandIn(operandIn),
    .carryIn(carryIn), .decReady(decReady), .execBusy(execBusy), .execDone(execDone),
    .execInfo(execInfo), .aluResult(aluResult), .aluCarry(aluCarry)
);

// file: tb/cpuitd_mem_model.sv
// Far side: internal RAM read port and code prefetch state.
// Assumes the bench drives address and prefetch state on clk_sys edges.
`timescale 1ns/1ps

module cpuitd_mem_model (
    input  wire logic [7:0] addr,
    input  wire logic [1:0] prefetchState,
    output logic      [7:0] rdData,
    output logic      [1:0] extraWait
);
    logic [7:0] ram [256];
    initial begin
        for (int i = 0; i < 256; i++) ram[i] = 8'(i * 37 + 11);
    end
    // Whole 8-bit space answers; upper half stands in for special registers
    assign rdData    = ram[addr];
    // Prefetch buffer state stretches code reads by up to three cycles
    assign extraWait = prefetchState;
endmodule

// file: tb/tb.sv
// Self-checking bench for the instruction length and timing decoder.
// Assumes the design package, the memory model and the bound checker are compiled first.
`timescale 1ns/1ps

module tb;
    logic                     clk_sys, rst, decReq, carryIn, decReady, execBusy, execDone, aluCarry;
    logic [7:0]               decOpcode, directAddr, accIn, operandIn, aluResult;
    logic [1:0]               bankSel, pfState, codeExtraWait;
    cpuitd_pkg::cpuitd_info_t execInfo;
    int                       n_fail, cmp_count, cycCnt;
    logic [7:0]               ops [$];

    cpuitd_decode uut (
        .clk_sys(clk_sys), .rst(rst), .decReq(decReq), .decOpcode(decOpcode), .directAddr(directAddr),
        .bankSel(bankSel), .codeExtraWait(codeExtraWait), .accIn(accIn), .operandIn(operandIn),
        .carryIn(carryIn), .decReady(decReady), .execBusy(execBusy), .execDone(execDone),
        .execInfo(execInfo), .aluResult(aluResult), .aluCarry(aluCarry)
    );
    cpuitd_mem_model mem (.addr(directAddr), .prefetchState(pfState), .rdData(operandIn), .extraWait(codeExtraWait));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Returns {bytes, cycles}
    function automatic logic [4:0] expLc(input logic [7:0] op, input logic [1:0] w);
        case (op)
            8'H85, 8'H90, 8'H43, 8'H53, 8'H63: return 5'H1B;
            8'H83, 8'HE0, 8'HE2, 8'HE3, 8'HF0, 8'HF2, 8'HF3: return 5'H0B;
            8'H76, 8'H77: return 5'H12;
            8'H93: return {2'H1, 3'H4 + {1'H0, w}};
            8'H03, 8'H13, 8'H23, 8'H33, 8'HA5: return 5'H09;
            default: return op[3] ? ((op[7:4] == 4'HA) ? 5'H12 : 5'H09) : ((op[3:1] == 3'H3) ? 5'H0A : 5'H12);
        endcase
    endfunction

    // Returns {check result, check carry, carry, result}
    function automatic logic [10:0] expAlu(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                                           input logic c);
        logic [8:0] r;
        logic [1:0] k;
        k = 2'H3;
        case (op[7:4])
            4'H2: r = {1'H0, a} + {1'H0, b};
            4'H3: r = {1'H0, a} + {1'H0, b} + {8'H0, c};
            4'H9: r = {1'H0, a} - {1'H0, b} - {8'H0, c};
            4'H4: r = {1'H0, a | b};
            4'H5: r = {1'H0, a & b};
            4'H6: r = {1'H0, a ^ b};
            default: r = 9'H0;
        endcase
        if (op[7:6] == 2'H1) k[0] = 1'H0;
        if (op[3:0] < 4'H4 || r === 9'H0 && !(op[7:4] inside {4'H2, 4'H3, 4'H4, 4'H5, 4'H6, 4'H9})) k = 2'H0;
        case (op)
            8'H03: {k, r} = {2'H2, 1'H0, a[0], a[7:1]};
            8'H13: {k, r} = {2'H3, a[0], c, a[7:1]};
            8'H23: {k, r} = {2'H2, 1'H0, a[6:0], a[7]};
            8'H33: {k, r} = {2'H3, a[7], a[6:0], c};
            default: ;
        endcase
        return {k, r};
    endfunction

    task automatic runOp(input logic [7:0] op, input logic [1:0] pf);
        logic [4:0]  lc;
        logic [10:0] al;
        logic [4:0]  rg;
        logic        sfr;
        logic        wr;
        int          n;
        @(posedge clk_sys);
        decReq     <= 1'H1;
        decOpcode  <= op;
        directAddr <= 8'($urandom);
        bankSel    <= 2'($urandom);
        accIn      <= 8'($urandom);
        carryIn    <= 1'($urandom);
        pfState    <= pf;
        @(posedge clk_sys);
        decReq <= 1'H0;
        lc  = expLc(op, codeExtraWait);
        al  = expAlu(op, accIn, operandIn, carryIn);
        rg  = op[3] ? {bankSel, op[2:0]} : {bankSel, 2'H0, op[0]};
        sfr = directAddr[7];
        wr  = op inside {8'H42, 8'H43, 8'H52, 8'H53, 8'H62, 8'H63, 8'H85, 8'HC5, 8'HD0};
        #1;
        n = 1;
        check(24'(execInfo.len), 24'(lc[4:3]));
        check(24'(execInfo.known), 24'(op != 8'HA5));
        check(24'(execInfo.cycles), 24'(lc[2:0]));
        check(24'(execInfo.wrDirect), 24'(wr));
        if (op[3] || op[3:1] == 3'H3) check(24'(execInfo.regAddr), 24'(rg));
        if (op[3:0] == 4'H5 && op != 8'HA5) check(24'(execInfo.dirIsSfr), 24'(sfr));
        if (al[10]) check(24'(aluResult), 24'(al[7:0]));
        if (al[9]) check(24'(aluCarry), 24'(al[8]));
        while (execDone !== 1'H1 && n < 9) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check(24'(n), 24'(lc[2:0]));
    endtask

    initial begin
        clk_sys = 1'H0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycCnt <= cycCnt + 1;
        if (cycCnt == 5000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        int n;
        {rst, decReq, carryIn, decOpcode, directAddr, accIn, bankSel, pfState} = {1'H1, 30'H0};
        {n_fail, cmp_count, cycCnt} = '0;
        n = $urandom(69960);
        ops = {8'H28, 8'H3D, 8'H9F, 8'H25, 8'H35, 8'H95, 8'H26, 8'H37, 8'H97,
                8'H24, 8'H34, 8'H94, 8'H55, 8'H45, 8'H65, 8'H52, 8'H42, 8'H62,
                8'H53, 8'H43, 8'H63, 8'H03, 8'H13, 8'H23, 8'H33, 8'HAB, 8'H85,
                8'HF6, 8'H76, 8'H90, 8'H83, 8'HE0, 8'HE3, 8'HF0, 8'HF2,
                8'HC0, 8'HD0, 8'HC5, 8'HD7, 8'H5E, 8'H46, 8'H67, 8'HA5};
        repeat (10) @(posedge clk_sys);
        rst <= 1'H0;
        repeat (3) foreach (ops[i]) runOp(ops[i], 2'($urandom));
        for (int w = 0; w < 4; w++) runOp(8'H93, 2'(w));
        // Request held high: each new take lands in the previous done cycle
        @(posedge clk_sys);
        decReq    <= 1'H1;
        decOpcode <= 8'H25;
        n = 0;
        for (int i = 1; i <= 8; i++) begin
            @(posedge clk_sys);
            if (i == 8) decReq <= 1'H0;
            #1;
            if (execDone === 1'H1) n++;
            check(24'(decReady), 24'(i % 2 == 0));
            check(24'(execBusy), 24'H1);
        end
        check(24'(n), 24'H4);
        // Reset in mid-instruction clears all state
        @(posedge clk_sys);
        decReq    <= 1'H1;
        decOpcode <= 8'H85;
        @(posedge clk_sys);
        decReq <= 1'H0;
        rst    <= 1'H1;
        @(posedge clk_sys);
        rst <= 1'H0;
        #1;
        check(24'({decReady, execBusy, execDone, aluResult, aluCarry}), 24'H800);
        check(24'(execInfo), 24'H0);
        conclude();
    end
endmodule
